// file: hpdr_map.vh
/*
  Register offsets, field positions, reset values, request source codes and
  pacing counts of the host port request generator.
  Assumes byte addressing on a 32-bit APB bus, one aligned word per register.
*/
`ifndef HPDR_MAP_VH
`define HPDR_MAP_VH

// Register byte offsets
`define HPDR_OFF_CHSEL0 8'h00
`define HPDR_OFF_SCTRL 8'h10
`define HPDR_OFF_MCTRL 8'h14
`define HPDR_OFF_PRIO 8'h18
`define HPDR_OFF_SSTAT 8'h1C
`define HPDR_OFF_MSTAT 8'h20
`define HPDR_OFF_CNT0 8'h24
`define HPDR_OFF_MODE 8'h34
`define HPDR_REG_STRIDE 8'h04

// Control fields: transmit enable in bit 0, receive enable in bit 1
`define HPDR_CTRL_TX_BIT 0
`define HPDR_CTRL_RX_BIT 1

// Status fields, per source pair: tx then rx
`define HPDR_ST_RDY_LSB 0
`define HPDR_ST_DMA_LSB 2
`define HPDR_ST_IRQ_LSB 4
`define HPDR_ST_HALF_LSB 6

// Reset values
`define HPDR_CHSEL_RST 5'h00
`define HPDR_CTRL_RST 2'h0
`define HPDR_PRIO_RST 2'h0

// Request source codes: base code is slave receive, then +1 per source
`define HPDR_DRS_BASE 5'h1C
`define HPDR_DRS_W 5
`define HPDR_PRIO_W 2

// Cycles a source stays quiet after each data access
`define HPDR_PACE_CYC 2'h1
`define HPDR_PACE_W 2

`endif

// file: hpdr_src_req.v
/*
  Qualifies one data source: ready flag, DMA request and interrupt request.
  Assumes all inputs are on clk_sys and the hold term comes from hpdr_pace.
*/
`timescale 1ns/1ns
module hpdr_src_req (
  input wire pci_mode,
  input wire fifo_ready,
  input wire sel_hit,
  input wire irq_en,
  input wire prio_ok,
  input wire hold,
  output wire ready_flag,
  output wire dma_req,
  output wire irq_req
);

  // Status flag follows the FIFO level while in PCI mode
  assign ready_flag = pci_mode & fifo_ready;

  // Level requests, dropped as soon as any condition falls
  assign dma_req = ready_flag & sel_hit & ~hold;
  assign irq_req = ready_flag & irq_en & prio_ok & ~hold;

endmodule // hpdr_src_req

// file: hpdr_pace.v
/*
  Per-source pacing and half-word sequencing.
  Assumes access pulses one cycle per data register access, on clk_sys.
*/
`timescale 1ns/1ns
`include "hpdr_map.vh"
module hpdr_pace (
  input wire clk_sys,
  input wire rst,
  input wire pci_mode,
  input wire wide32,
  input wire access,
  output wire hold,
  output reg half_hi_reg,
  output reg word_done_reg
);

  reg [`HPDR_PACE_W-1:0] hold_reg;

  assign hold = (hold_reg != {`HPDR_PACE_W{1'b0}});

  // Quiet gap after each access, low half then high half in 32-bit mode
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      hold_reg <= {`HPDR_PACE_W{1'b0}};
      half_hi_reg <= 1'b0;
      word_done_reg <= 1'b0;
    end else begin
      word_done_reg <= 1'b0;
      if (!pci_mode) begin
        hold_reg <= {`HPDR_PACE_W{1'b0}};
        half_hi_reg <= 1'b0;
      end else if (access) begin
        hold_reg <= `HPDR_PACE_CYC;
        if (wide32 && !half_hi_reg) begin
          half_hi_reg <= 1'b1;
        end else begin
          half_hi_reg <= 1'b0;
          word_done_reg <= 1'b1;
        end
      end else if (hold) begin
        hold_reg <= hold_reg - 1'b1;
      end
    end
  end

endmodule // hpdr_pace

// file: hpdr_req_gen.v
/*
  Host port DMA and interrupt request generator with an APB register file.
  Four sources: slave receive, master receive, slave transmit, master
  transmit. Assumes FIFO status, access pulses, mode and core mask level come
  from logic on clk_sys, so no synchronisers are needed.
*/
`timescale 1ns/1ns
`include "hpdr_map.vh"
module hpdr_req_gen #(
  parameter NUM_CH = 4,
  parameter CNT_W = 16
) (
  input wire clk_sys,
  input wire rst,
  input wire [7:0] paddr,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire pci_mode,
  input wire wide32_mode,
  input wire [`HPDR_PRIO_W-1:0] core_irq_mask_level,
  input wire slave_tx_fifo_full,
  input wire master_tx_fifo_full,
  input wire rx_fifo_empty,
  input wire rx_fifo_head_master,
  input wire slave_rx_access,
  input wire master_rx_access,
  input wire slave_tx_access,
  input wire master_tx_access,
  output reg [NUM_CH-1:0] dma_ch_req,
  output wire slave_rx_irq,
  output wire master_rx_irq,
  output wire slave_tx_irq,
  output wire master_tx_irq,
  output wire slave_rx_half_hi,
  output wire master_rx_half_hi,
  output wire slave_tx_half_hi,
  output wire master_tx_half_hi
);

  // Source indices
  localparam SRC_SR = 0;
  localparam SRC_MR = 1;
  localparam SRC_ST = 2;
  localparam SRC_MT = 3;
  localparam NUM_SRC = 4;

  // Configuration held by software
  reg [`HPDR_DRS_W-1:0] chsel_reg [0:NUM_CH-1];
  reg [1:0] slave_ctrl_reg;
  reg [1:0] master_ctrl_reg;
  reg [`HPDR_PRIO_W-1:0] prio_reg;
  reg [CNT_W-1:0] cnt_reg [0:NUM_SRC-1];

  // Per-source working signals
  wire [NUM_SRC-1:0] access_vec;
  wire [NUM_SRC-1:0] fifo_ready_vec;
  wire [NUM_SRC-1:0] irq_en_vec;
  wire [NUM_SRC-1:0] hold_vec;
  wire [NUM_SRC-1:0] half_vec;
  wire [NUM_SRC-1:0] done_vec;
  wire [NUM_SRC-1:0] ready_vec;
  wire [NUM_SRC-1:0] dma_vec;
  wire [NUM_SRC-1:0] irq_vec;
  reg [NUM_SRC-1:0] sel_hit_vec;
  wire prio_ok;

  // APB phase decode
  wire setup_ph;
  wire access_ph;
  wire wr_en;
  reg [31:0] rdata_next;
  reg hit_next;
  reg hit_reg_q;

  integer ch_rd;
  integer s_rd;
  integer ch_wr;
  integer s_cnt;
  integer s_hit;
  integer ch_hit;
  integer ch_rt;
  integer s_rt;
  genvar g;

  // Code that selects a given source
  function [`HPDR_DRS_W-1:0] src_code;
    input integer idx;
    reg [31:0] tmp;
    begin
      tmp = idx;
      src_code = `HPDR_DRS_BASE + tmp[`HPDR_DRS_W-1:0];
    end
  endfunction

  // Byte address of the n-th register of a block
  function [7:0] reg_addr;
    input [7:0] base;
    input integer idx;
    reg [31:0] tmp;
    begin
      tmp = idx;
      reg_addr = base + {tmp[5:0], 2'b00};
    end
  endfunction

  // Packs tx and rx pairs into the status register layout
  function [31:0] pack_stat;
    input [1:0] rdy;
    input [1:0] dma;
    input [1:0] irq;
    input [1:0] half;
    begin
      pack_stat = 32'h0000_0000;
      pack_stat[`HPDR_ST_RDY_LSB+1:`HPDR_ST_RDY_LSB] = rdy;
      pack_stat[`HPDR_ST_DMA_LSB+1:`HPDR_ST_DMA_LSB] = dma;
      pack_stat[`HPDR_ST_IRQ_LSB+1:`HPDR_ST_IRQ_LSB] = irq;
      pack_stat[`HPDR_ST_HALF_LSB+1:`HPDR_ST_HALF_LSB] = half;
    end
  endfunction

  // Zero-wait slave: answer in the first access cycle
  assign setup_ph = psel & ~penable;
  assign access_ph = psel & penable;
  assign wr_en = access_ph & pwrite & hit_reg_q;
  assign pready = 1'b1;
  assign pslverr = access_ph & ~hit_reg_q;

  // Address hit caught in setup, used in access
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      hit_reg_q <= 1'b0;
    end else if (setup_ph) begin
      hit_reg_q <= hit_next;
    end
  end

  // Read data and hit decode
  always @* begin
    rdata_next = 32'h0000_0000;
    hit_next = 1'b0;
    for (ch_rd = 0; ch_rd < NUM_CH; ch_rd = ch_rd + 1) begin
      if (paddr == reg_addr(`HPDR_OFF_CHSEL0, ch_rd)) begin
        hit_next = 1'b1;
        rdata_next[`HPDR_DRS_W-1:0] = chsel_reg[ch_rd];
      end
    end
    for (s_rd = 0; s_rd < NUM_SRC; s_rd = s_rd + 1) begin
      if (paddr == reg_addr(`HPDR_OFF_CNT0, s_rd)) begin
        hit_next = 1'b1;
        rdata_next[CNT_W-1:0] = cnt_reg[s_rd];
      end
    end
    case (paddr)
      `HPDR_OFF_SCTRL: begin
        hit_next = 1'b1;
        rdata_next[1:0] = slave_ctrl_reg;
      end
      `HPDR_OFF_MCTRL: begin
        hit_next = 1'b1;
        rdata_next[1:0] = master_ctrl_reg;
      end
      `HPDR_OFF_PRIO: begin
        hit_next = 1'b1;
        rdata_next[`HPDR_PRIO_W-1:0] = prio_reg;
      end
      `HPDR_OFF_SSTAT: begin
        hit_next = 1'b1;
        rdata_next = pack_stat({ready_vec[SRC_SR], ready_vec[SRC_ST]},
                               {dma_vec[SRC_SR], dma_vec[SRC_ST]},
                               {irq_vec[SRC_SR], irq_vec[SRC_ST]},
                               {half_vec[SRC_SR], half_vec[SRC_ST]});
      end
      `HPDR_OFF_MSTAT: begin
        hit_next = 1'b1;
        rdata_next = pack_stat({ready_vec[SRC_MR], ready_vec[SRC_MT]},
                               {dma_vec[SRC_MR], dma_vec[SRC_MT]},
                               {irq_vec[SRC_MR], irq_vec[SRC_MT]},
                               {half_vec[SRC_MR], half_vec[SRC_MT]});
      end
      `HPDR_OFF_MODE: begin
        hit_next = 1'b1;
        rdata_next[1:0] = {wide32_mode, pci_mode};
      end
      default: begin
        rdata_next = rdata_next;
      end
    endcase
  end

  // Read data registered in setup, valid through the access cycle
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      prdata <= 32'h0000_0000;
    end else if (setup_ph && !pwrite) begin
      prdata <= rdata_next;
    end
  end

  // Channel source selects
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      for (ch_wr = 0; ch_wr < NUM_CH; ch_wr = ch_wr + 1) begin
        chsel_reg[ch_wr] <= `HPDR_CHSEL_RST;
      end
    end else if (wr_en) begin
      for (ch_wr = 0; ch_wr < NUM_CH; ch_wr = ch_wr + 1) begin
        if (paddr == reg_addr(`HPDR_OFF_CHSEL0, ch_wr)) begin
          chsel_reg[ch_wr] <= pwdata[`HPDR_DRS_W-1:0];
        end
      end
    end
  end

  // Interrupt enables and port priority level
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      slave_ctrl_reg <= `HPDR_CTRL_RST;
      master_ctrl_reg <= `HPDR_CTRL_RST;
      prio_reg <= `HPDR_PRIO_RST;
    end else if (wr_en) begin
      if (paddr == `HPDR_OFF_SCTRL) begin
        slave_ctrl_reg <= pwdata[1:0];
      end
      if (paddr == `HPDR_OFF_MCTRL) begin
        master_ctrl_reg <= pwdata[1:0];
      end
      if (paddr == `HPDR_OFF_PRIO) begin
        prio_reg <= pwdata[`HPDR_PRIO_W-1:0];
      end
    end
  end

  // Word counters, cleared by a write to their own register; a word finishing then counts 1
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      for (s_cnt = 0; s_cnt < NUM_SRC; s_cnt = s_cnt + 1) begin
        cnt_reg[s_cnt] <= {CNT_W{1'b0}};
      end
    end else begin
      for (s_cnt = 0; s_cnt < NUM_SRC; s_cnt = s_cnt + 1) begin
        if (wr_en && paddr == reg_addr(`HPDR_OFF_CNT0, s_cnt)) begin
          cnt_reg[s_cnt] <= {{(CNT_W-1){1'b0}}, done_vec[s_cnt]};
        end else if (done_vec[s_cnt]) begin
          cnt_reg[s_cnt] <= cnt_reg[s_cnt] + 1'b1;
        end
      end
    end
  end

  // Source inputs gathered by index
  assign access_vec[SRC_SR] = slave_rx_access;
  assign access_vec[SRC_MR] = master_rx_access;
  assign access_vec[SRC_ST] = slave_tx_access;
  assign access_vec[SRC_MT] = master_tx_access;

  // Ready conditions of the three FIFOs
  assign fifo_ready_vec[SRC_ST] = ~slave_tx_fifo_full;
  assign fifo_ready_vec[SRC_SR] = ~rx_fifo_empty & ~rx_fifo_head_master;
  assign fifo_ready_vec[SRC_MT] = ~master_tx_fifo_full;
  assign fifo_ready_vec[SRC_MR] = ~rx_fifo_empty & rx_fifo_head_master;

  // Enables from the slave and master control registers
  assign irq_en_vec[SRC_ST] = slave_ctrl_reg[`HPDR_CTRL_TX_BIT];
  assign irq_en_vec[SRC_SR] = slave_ctrl_reg[`HPDR_CTRL_RX_BIT];
  assign irq_en_vec[SRC_MT] = master_ctrl_reg[`HPDR_CTRL_TX_BIT];
  assign irq_en_vec[SRC_MR] = master_ctrl_reg[`HPDR_CTRL_RX_BIT];

  // Port level must be strictly above the core mask
  assign prio_ok = (prio_reg > core_irq_mask_level);

  // Which sources some channel currently selects
  always @* begin
    sel_hit_vec = {NUM_SRC{1'b0}};
    for (s_hit = 0; s_hit < NUM_SRC; s_hit = s_hit + 1) begin
      for (ch_hit = 0; ch_hit < NUM_CH; ch_hit = ch_hit + 1) begin
        if (chsel_reg[ch_hit] == src_code(s_hit)) begin
          sel_hit_vec[s_hit] = 1'b1;
        end
      end
    end
  end

  // One pacer and one qualifier per source
  generate
    for (g = 0; g < NUM_SRC; g = g + 1) begin : src
      hpdr_pace u_pace (
        .clk_sys(clk_sys),
        .rst(rst),
        .pci_mode(pci_mode),
        .wide32(wide32_mode),
        .access(access_vec[g]),
        .hold(hold_vec[g]),
        .half_hi_reg(half_vec[g]),
        .word_done_reg(done_vec[g])
      );
      hpdr_src_req u_req (
        .pci_mode(pci_mode),
        .fifo_ready(fifo_ready_vec[g]),
        .sel_hit(sel_hit_vec[g]),
        .irq_en(irq_en_vec[g]),
        .prio_ok(prio_ok),
        .hold(hold_vec[g]),
        .ready_flag(ready_vec[g]),
        .dma_req(dma_vec[g]),
        .irq_req(irq_vec[g])
      );
    end
  endgenerate

  // Route each source request to the channels selecting it
  always @* begin
    dma_ch_req = {NUM_CH{1'b0}};
    for (ch_rt = 0; ch_rt < NUM_CH; ch_rt = ch_rt + 1) begin
      for (s_rt = 0; s_rt < NUM_SRC; s_rt = s_rt + 1) begin
        if (chsel_reg[ch_rt] == src_code(s_rt) && dma_vec[s_rt]) begin
          dma_ch_req[ch_rt] = 1'b1;
        end
      end
    end
  end

  // Four separate interrupt lines
  assign slave_rx_irq = irq_vec[SRC_SR];
  assign master_rx_irq = irq_vec[SRC_MR];
  assign slave_tx_irq = irq_vec[SRC_ST];
  assign master_tx_irq = irq_vec[SRC_MT];

  // Which half of a 32-bit word the next access moves
  assign slave_rx_half_hi = half_vec[SRC_SR];
  assign master_rx_half_hi = half_vec[SRC_MR];
  assign slave_tx_half_hi = half_vec[SRC_ST];
  assign master_tx_half_hi = half_vec[SRC_MT];

endmodule // hpdr_req_gen

// file: hpdr_req_gen_monitor.sv
/* Assertion checker for the host port request generator outputs.
   Assumes it is bound to hpdr_req_gen and sees only its ports. */
`timescale 1ns/1ns
`include "hpdr_map.vh"
module hpdr_req_monitor #(
  parameter NUM_CH = 4
) (
  input wire clk_sys,
  input wire rst,
  input wire pci_mode,
  input wire wide32_mode,
  input wire [`HPDR_PRIO_W-1:0] core_irq_mask_level,
  input wire slave_tx_fifo_full,
  input wire master_tx_fifo_full,
  input wire rx_fifo_empty,
  input wire rx_fifo_head_master,
  input wire slave_tx_access,
  input wire [NUM_CH-1:0] dma_ch_req,
  input wire slave_rx_irq,
  input wire master_rx_irq,
  input wire slave_tx_irq,
  input wire master_tx_irq,
  input wire slave_tx_half_hi
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  // Request conditions at the outputs
  req_off_pci_a: assert property (
    !pci_mode |-> dma_ch_req == 0 && !slave_tx_irq && !slave_rx_irq
    && !master_tx_irq && !master_rx_irq) else $error("request outside pci mode");
  stx_irq_cond_a: assert property (
    slave_tx_irq |-> pci_mode && !slave_tx_fifo_full && core_irq_mask_level != 2'h3)
    else $error("slave tx irq unqualified");
  srx_irq_cond_a: assert property (
    slave_rx_irq |-> pci_mode && !rx_fifo_empty && !rx_fifo_head_master)
    else $error("slave rx irq unqualified");
  mtx_irq_cond_a: assert property (
    master_tx_irq |-> pci_mode && !master_tx_fifo_full && core_irq_mask_level != 2'h3)
    else $error("master tx irq unqualified");
  mrx_irq_cond_a: assert property (
    master_rx_irq |-> pci_mode && !rx_fifo_empty && rx_fifo_head_master)
    else $error("master rx irq unqualified");
  // Pacing and half word order
  stx_hold_a: assert property (
    slave_tx_access |=> !slave_tx_irq) else $error("slave tx irq not held after access");
  half_set_a: assert property (
    slave_tx_access && pci_mode && wide32_mode && !slave_tx_half_hi |=> slave_tx_half_hi)
    else $error("high half not next");
  half_clr_a: assert property (
    slave_tx_access && pci_mode && slave_tx_half_hi |=> !slave_tx_half_hi)
    else $error("word not completed");
  half_off_a: assert property (
    !pci_mode [*2] |-> !slave_tx_half_hi) else $error("half state kept outside pci mode");
endmodule // hpdr_req_monitor

bind hpdr_req_gen hpdr_req_monitor #(.NUM_CH(NUM_CH)) u_mon (.clk_sys(clk_sys), .rst(rst),
  .pci_mode(pci_mode), .wide32_mode(wide32_mode), .core_irq_mask_level(core_irq_mask_level),
  .slave_tx_fifo_full(slave_tx_fifo_full), .master_tx_fifo_full(master_tx_fifo_full),
  .rx_fifo_empty(rx_fifo_empty), .rx_fifo_head_master(rx_fifo_head_master),
  .slave_tx_access(slave_tx_access), .dma_ch_req(dma_ch_req), .slave_rx_irq(slave_rx_irq),
  .master_rx_irq(master_rx_irq), .slave_tx_irq(slave_tx_irq), .master_tx_irq(master_tx_irq),
  .slave_tx_half_hi(slave_tx_half_hi));

// file: hpdr_dma_model.sv
/* Behavioural DMA channel serving one host port data register.
   Assumes a level request on clk_sys; access is a one-cycle pulse. */
`timescale 1ns/1ns
module hpdr_dma_model (
  input wire clk_sys,
  input wire rst,
  input wire run,
  input wire slow,
  input wire req,
  output reg access,
  output reg [7:0] acc_count
);
  reg [1:0] tick_reg;

  // One word per sampled request, slow mode every fourth cycle only
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      tick_reg <= 2'h0;
      access <= 1'b0;
      acc_count <= 8'h00;
    end else begin
      tick_reg <= tick_reg + 2'h1;
      access <= run && req && !access && (!slow || tick_reg == 2'h0);
      if (access) begin
        acc_count <= acc_count + 8'h01;
      end
    end
  end
endmodule // hpdr_dma_model

// file: test_hpdr_req_gen.sv
/* Self-checking testbench for hpdr_req_gen.
   Assumes the checker is bound and the DMA model serves slave transmit. */
`timescale 1ns/1ns
module test_hpdr_req_gen;
  reg clk_sys = 1'b0;
  reg rst = 1'b1;
  reg [7:0] paddr = 8'h00;
  reg psel = 1'b0;
  reg penable = 1'b0;
  reg pwrite = 1'b0;
  reg [31:0] pwdata = 32'h0;
  reg pci = 1'b0;
  reg wide = 1'b0;
  reg [1:0] mask = 2'h0;
  reg stx_full = 1'b0;
  reg mtx_full = 1'b0;
  reg rx_empty = 1'b1;
  reg head_m = 1'b0;
  reg [3:0] acc_tb = 4'h0;
  reg run = 1'b0;
  reg slow = 1'b0;
  reg [31:0] v;
  reg err;
  reg [7:0] base;
  integer i, j;
  integer fail_count = 0;
  integer num_checks = 0;
  wire [31:0] prdata;
  wire pready, pslverr, dma_acc;
  wire [3:0] dma_ch_req, irq, half;
  wire [7:0] acc_count;
  wire [3:0] acc = acc_tb | {1'b0, dma_acc, 2'h0};

  initial forever #20 clk_sys = ~clk_sys;

  hpdr_req_gen dut (.clk_sys(clk_sys), .rst(rst), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pci_mode(pci), .wide32_mode(wide), .core_irq_mask_level(mask),
    .slave_tx_fifo_full(stx_full), .master_tx_fifo_full(mtx_full), .rx_fifo_empty(rx_empty),
    .rx_fifo_head_master(head_m), .slave_rx_access(acc[0]), .master_rx_access(acc[1]),
    .slave_tx_access(acc[2]), .master_tx_access(acc[3]), .dma_ch_req(dma_ch_req),
    .slave_rx_irq(irq[0]), .master_rx_irq(irq[1]), .slave_tx_irq(irq[2]),
    .master_tx_irq(irq[3]), .slave_rx_half_hi(half[0]), .master_rx_half_hi(half[1]),
    .slave_tx_half_hi(half[2]), .master_tx_half_hi(half[3]));
  hpdr_dma_model dma (.clk_sys(clk_sys), .rst(rst), .run(run), .slow(slow),
    .req(dma_ch_req[0]), .access(dma_acc), .acc_count(acc_count));

  task give_verdict;
    begin
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0)
        $display("Finished cleanly");
      else
        $display("Finished with errors");
      $finish;
    end
  endtask

  task chk(input [31:0] got, input [31:0] exp);
    begin
      num_checks = num_checks + 1;
      if (got !== exp) begin
        fail_count = fail_count + 1;
        $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
    end
  endtask

  // One APB transfer; read data and error land in v and err
  task apb(input w, input [7:0] a, input [31:0] d);
    integer n;
    begin
      @(posedge clk_sys);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      n = 0;
      @(posedge clk_sys);
      while (pready !== 1'b1 && n < 20) begin
        n = n + 1;
        @(posedge clk_sys);
      end
      if (n == 20) begin
        fail_count = fail_count + 1;
        give_verdict;
      end
      v = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask

  task test_reset;
    begin
      @(negedge clk_sys);
      chk({dma_ch_req, irq, half, pready}, 32'h1);
      apb(1'b0, 8'h00, 32'h0);
      chk(v, 32'h0);
      $display("test_reset done");
    end
  endtask

  task test_codes;
    begin
      pci <= 1'b1;
      rx_empty <= 1'b0;
      for (i = 0; i < 4; i = i + 1) begin
        for (j = 0; j < 2; j = j + 1) begin
          head_m <= j[0];
          apb(1'b1, 8'h00, 32'h1C + i);
          @(negedge clk_sys);
          chk(dma_ch_req[0], i > 1 || (i == 1) == (j == 1));
        end
      end
      apb(1'b1, 8'h00, 32'h1B);
      @(negedge clk_sys);
      chk(dma_ch_req[0], 1'b0);
      apb(1'b1, 8'h00, 32'h1F);
      apb(1'b1, 8'h04, 32'h1D);
      apb(1'b1, 8'h0C, 32'h1E);
      @(negedge clk_sys);
      chk(dma_ch_req, 4'hB);
      @(posedge clk_sys);
      pci <= 1'b0;
      @(negedge clk_sys);
      chk(dma_ch_req, 4'h0);
      apb(1'b1, 8'h04, 32'h0);
      apb(1'b1, 8'h0C, 32'h0);
      pci <= 1'b1;
      $display("test_codes done");
    end
  endtask

  task test_irq;
    begin
      apb(1'b1, 8'h00, 32'h0);
      apb(1'b1, 8'h10, 32'h3);
      apb(1'b1, 8'h14, 32'h3);
      apb(1'b1, 8'h18, 32'h2);
      head_m <= 1'b0;
      mask <= 2'h1;
      @(negedge clk_sys);
      chk(irq, 4'hD);
      apb(1'b0, 8'h1C, 32'h0);
      chk(v, 32'h33);
      apb(1'b0, 8'h20, 32'h0);
      chk(v, 32'h11);
      mask <= 2'h2;
      @(negedge clk_sys);
      chk(irq, 4'h0);
      @(posedge clk_sys);
      mask <= 2'h1;
      apb(1'b1, 8'h10, 32'h0);
      @(negedge clk_sys);
      chk(irq, 4'h8);
      @(posedge clk_sys);
      mtx_full <= 1'b1;
      @(negedge clk_sys);
      chk(irq, 4'h0);
      @(posedge clk_sys);
      mtx_full <= 1'b0;
      apb(1'b1, 8'h10, 32'h3);
      $display("test_irq done");
    end
  endtask

  // Two half-word accesses on both transmit sources in 32-bit mode
  task test_hold;
    begin
      wide <= 1'b1;
      apb(1'b1, 8'h00, 32'h1E);
      for (i = 0; i < 2; i = i + 1) begin
        @(posedge clk_sys);
        acc_tb <= 4'hC;
        @(posedge clk_sys);
        acc_tb <= 4'h0;
        @(negedge clk_sys);
        chk({irq[3:2], dma_ch_req[0], half[3:2]}, i ? 5'h00 : 5'h03);
        @(negedge clk_sys);
        chk({irq[3:2], dma_ch_req[0]}, 3'h7);
      end
      apb(1'b0, 8'h2C, 32'h0);
      chk(v, 32'h1);
      apb(1'b0, 8'h30, 32'h0);
      chk(v, 32'h1);
      $display("test_hold done");
    end
  endtask

  // DMA partner fast then slow, with a stall of the FIFO mid-run
  task test_dma;
    begin
      for (i = 0; i < 2; i = i + 1) begin
        wide <= i[0];
        slow <= i[0];
        apb(1'b1, 8'h2C, 32'h0);
        base = acc_count;
        run <= 1'b1;
        repeat (30) @(posedge clk_sys);
        stx_full <= 1'b1;
        @(negedge clk_sys);
        chk(dma_ch_req[0], 1'b0);
        repeat (10) @(posedge clk_sys);
        stx_full <= 1'b0;
        repeat (30) @(posedge clk_sys);
        run <= 1'b0;
        repeat (3) @(posedge clk_sys);
        apb(1'b0, 8'h2C, 32'h0);
        chk(v, (acc_count - base) >> i);
        chk(acc_count != base, 1'b1);
      end
      $display("test_dma done");
    end
  endtask

  task test_unmapped;
    begin
      apb(1'b0, 8'hFC, 32'h0);
      chk(v, 32'h0);
      chk(err, 1'b1);
      $display("test_unmapped done");
    end
  endtask

  initial begin
    repeat (8) @(posedge clk_sys);
    rst <= 1'b0;
    test_reset;
    test_codes;
    test_irq;
    test_hold;
    test_dma;
    test_unmapped;
    give_verdict;
  end
endmodule // test_hpdr_req_gen
